// ==== lmf_pkg.sv ====
package lmf_pkg;
	// ==========================================
	// Matrix geometry
	localparam int ROWS = 11;
	localparam int COLS = 18;
	localparam int LEDS = ROWS * COLS;
	localparam int PWM_W = 8;
	localparam int ROW_W = 4;
	localparam int COL_W = 5;

	// ==========================================
	// Scan timing
	localparam int CLK_PERIOD_NS = 40;
	localparam int BLANK_TIME_NS = 830;
	localparam int BLANK_CYC =
		(BLANK_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam logic [7:0] BLANK_LAST = 8'(BLANK_CYC - 1);
	localparam logic [7:0] STEP_LAST = 8'hff;
	localparam logic [7:0] SAMPLE_STEP = 8'h01;
	localparam logic [3:0] ROW_LAST = 4'(ROWS - 1);

	// ==========================================
	// Detect select codes
	localparam logic [1:0] DET_OFF = 2'h0;
	localparam logic [1:0] DET_OPEN = 2'h1;
	localparam logic [1:0] DET_SHORT = 2'h2;

	// ==========================================
	// Pull resistor selection codes
	localparam logic [7:0] PULL_NONE = 8'h00;
	localparam logic [7:0] PULL_ROW_UP = 8'h30;

	// ==========================================
	// Reset values
	localparam logic [7:0] RST_CNT = 8'h00;
	localparam logic [3:0] RST_ROW = 4'h0;

	typedef enum logic {SC_BLANK, SC_DRIVE} lmf_scan_t;
	typedef enum logic [1:0] {DT_IDLE, DT_WAIT, DT_RUN} lmf_det_t;
endpackage

// ==== lmf_pwm_mem.sv ====
module lmf_pwm_mem #(
	parameter int LANES = 18,
	parameter int LANE_W = 8,
	parameter int DEPTH = 11,
	parameter int AW = 4
) (
	// Clock
	input  wire logic                    mclk,
	// Write side
	input  wire logic                    wr_en,
	input  wire logic [AW-1:0]           wr_addr,
	input  wire logic [LANES-1:0]        wr_lane,
	input  wire logic [LANE_W-1:0]       wr_data,
	// Read side
	input  wire logic [AW-1:0]           rd_addr,
	output logic      [LANES*LANE_W-1:0] rd_data
);
	logic [LANES*LANE_W-1:0] mem [DEPTH];

	// ==========================================
	// Byte-lane write, registered read
	always_ff @(posedge mclk) begin
		for (int l = 0; l < LANES; l++) begin
			if (wr_en && wr_lane[l] && (int'(wr_addr) < DEPTH)) begin
				mem[wr_addr][l*LANE_W +: LANE_W] <= wr_data;
			end
		end
		rd_data <= (int'(rd_addr) < DEPTH) ? mem[rd_addr] : '0;
	end
endmodule

// ==== lmf_matrix_ctrl.sv ====
// Behaviour
// R1: Only PWM mode, 256 steps per LED
// R2: PWM value is plain binary step count
// R3: Detect select 00 to 01/10 starts capture
// R4: Host waits two scans before reading results
// R5: Disabled LEDs keep old result bits
// R6: Host sets current and pulls before detecting
// R7: Selection 0x30 enables row switch pull-up
// R8: One pass per trigger; clear before retrigger
// R9: Selectable row pull-downs, column pull-ups
// R10: Pulls connect only while output is off
// R11: Registers retained in either shutdown
// R12: Soft shutdown blanks all sinks
// R13: Shutdown pin low disables, high resumes
// R14: Register writes accepted during hardware shutdown
// R15: Separate open and short bit per LED
// R16: Select 01 runs one open pass
// R17: Select 10 runs one short pass
// R18: Results held until next pass overwrites
module lmf_matrix_ctrl (
	// Clock and reset
	input  wire logic                        mclk,
	input  wire logic                        rst_n,
	// Per-LED PWM write port
	input  wire logic                        pwm_wr_en,
	input  wire logic [lmf_pkg::ROW_W-1:0]   pwm_wr_row,
	input  wire logic [lmf_pkg::COL_W-1:0]   pwm_wr_col,
	input  wire logic [lmf_pkg::PWM_W-1:0]   pwm_wr_data,
	// Configuration
	input  wire logic [lmf_pkg::LEDS-1:0]    led_enable,
	input  wire logic [1:0]                  detect_select,
	input  wire logic [7:0]                  pull_select,
	input  wire logic                        soft_shutdown_n,
	input  wire logic                        shutdown_pin_n,
	// Fault sense from the column comparators
	input  wire logic [lmf_pkg::COLS-1:0]    fault_sense,
	// Matrix drive
	output logic      [lmf_pkg::ROWS-1:0]    row_switch_ff,
	output logic      [lmf_pkg::COLS-1:0]    column_sink_ff,
	output logic      [lmf_pkg::ROWS-1:0]    row_pulldown_ff,
	output logic      [lmf_pkg::ROWS-1:0]    row_pullup_ff,
	output logic      [lmf_pkg::COLS-1:0]    column_pullup_ff,
	// Status and results
	output logic                             detect_busy_ff,
	output logic                             analog_on_ff,
	output logic      [lmf_pkg::LEDS-1:0]    open_result_ff,
	output logic      [lmf_pkg::LEDS-1:0]    short_result_ff
);
	// ==========================================
	// Pull selection decode
	function automatic logic pull_any(input logic [7:0] sel);
		return sel != lmf_pkg::PULL_NONE;
	endfunction

	function automatic logic pull_row_up(input logic [7:0] sel);
		return sel == lmf_pkg::PULL_ROW_UP;
	endfunction

	// ==========================================
	// PWM storage
	logic [lmf_pkg::COLS-1:0]             wr_lane;
	logic [lmf_pkg::ROW_W-1:0]            rd_row;
	logic [lmf_pkg::COLS*lmf_pkg::PWM_W-1:0] row_pwm;

	// Writes go through in every mode, so nothing is lost [R11] [R14]
	always_comb begin
		wr_lane = '0;
		if (int'(pwm_wr_col) < lmf_pkg::COLS) begin
			wr_lane[pwm_wr_col] = 1'b1;
		end
	end

	lmf_pwm_mem #(
		.LANES  (lmf_pkg::COLS),
		.LANE_W (lmf_pkg::PWM_W),
		.DEPTH  (lmf_pkg::ROWS),
		.AW     (lmf_pkg::ROW_W)
	) u_pwm_mem (
		.mclk    (mclk),
		.wr_en   (pwm_wr_en),
		.wr_addr (pwm_wr_row),
		.wr_lane (wr_lane),
		.wr_data (pwm_wr_data),
		.rd_addr (rd_row),
		.rd_data (row_pwm)
	);

	// ==========================================
	// Scan sequencer
	lmf_pkg::lmf_scan_t        scan_ff;
	lmf_pkg::lmf_scan_t        nxt_scan;
	logic [3:0]                row_ff;
	logic [3:0]                nxt_row;
	logic [7:0]                cnt_ff;
	logic [7:0]                nxt_cnt;
	logic                      shut;
	logic                      blank_all;
	logic                      scan_wrap;

	assign shut = !shutdown_pin_n; // [R13]
	assign blank_all = shut || !soft_shutdown_n; // [R12]
	assign rd_row = row_ff;
	// Frozen scan must not keep signalling a wrap
	assign scan_wrap = !shut && (scan_ff == lmf_pkg::SC_DRIVE) &&
		(cnt_ff == lmf_pkg::STEP_LAST) && (row_ff == lmf_pkg::ROW_LAST);

	always_comb begin
		nxt_scan = scan_ff;
		nxt_row = row_ff;
		nxt_cnt = cnt_ff;
		// Scan freezes while the analog side is off [R13]
		if (!shut) begin
			unique case (scan_ff)
				lmf_pkg::SC_BLANK: begin
					if (cnt_ff == lmf_pkg::BLANK_LAST) begin
						nxt_scan = lmf_pkg::SC_DRIVE;
						nxt_cnt = lmf_pkg::RST_CNT;
					end else begin
						nxt_cnt = cnt_ff + 8'h01;
					end
				end
				lmf_pkg::SC_DRIVE: begin
					if (cnt_ff == lmf_pkg::STEP_LAST) begin // [R1]
						nxt_scan = lmf_pkg::SC_BLANK;
						nxt_cnt = lmf_pkg::RST_CNT;
						nxt_row = (row_ff == lmf_pkg::ROW_LAST) ?
							lmf_pkg::RST_ROW : row_ff + 4'h1;
					end else begin
						nxt_cnt = cnt_ff + 8'h01;
					end
				end
			endcase
		end
	end

	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			scan_ff <= lmf_pkg::SC_BLANK;
			row_ff <= lmf_pkg::RST_ROW;
			cnt_ff <= lmf_pkg::RST_CNT;
		end else begin
			scan_ff <= nxt_scan;
			row_ff <= nxt_row;
			cnt_ff <= nxt_cnt;
		end
	end

	// ==========================================
	// Row and column drive with de-ghost pulls
	logic [lmf_pkg::ROWS-1:0] nxt_row_sw;
	logic [lmf_pkg::COLS-1:0] nxt_col_sink;
	logic [lmf_pkg::ROWS-1:0] nxt_row_pd;
	logic [lmf_pkg::ROWS-1:0] nxt_row_pu;
	logic [lmf_pkg::COLS-1:0] nxt_col_pu;
	logic                     driving;

	assign driving = (scan_ff == lmf_pkg::SC_DRIVE) && !blank_all;

	always_comb begin
		nxt_row_sw = '0;
		if (driving) begin
			nxt_row_sw[row_ff] = 1'b1;
		end
	end

	generate
		for (genvar c = 0; c < lmf_pkg::COLS; c++) begin : g_col
			// Count below the stored value: value 4 lights 4 steps [R2]
			assign nxt_col_sink[c] = driving &&
				(cnt_ff < row_pwm[c*lmf_pkg::PWM_W +: lmf_pkg::PWM_W]);
			assign nxt_col_pu[c] = pull_any(pull_select) &&
				!nxt_col_sink[c]; // [R9] [R10]
		end
		for (genvar r = 0; r < lmf_pkg::ROWS; r++) begin : g_row
			assign nxt_row_pu[r] = pull_row_up(pull_select) &&
				!nxt_row_sw[r]; // [R7] [R10]
			assign nxt_row_pd[r] = pull_any(pull_select) &&
				!pull_row_up(pull_select) && !nxt_row_sw[r]; // [R9] [R10]
		end
	endgenerate

	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			row_switch_ff <= '0;
			column_sink_ff <= '0;
			row_pulldown_ff <= '0;
			row_pullup_ff <= '0;
			column_pullup_ff <= '0;
			analog_on_ff <= 1'b0;
		end else begin
			row_switch_ff <= nxt_row_sw;
			column_sink_ff <= nxt_col_sink;
			row_pulldown_ff <= shut ? '0 : nxt_row_pd;
			row_pullup_ff <= shut ? '0 : nxt_row_pu;
			column_pullup_ff <= shut ? '0 : nxt_col_pu;
			analog_on_ff <= !shut;
		end
	end

	// ==========================================
	// Open/short detection
	lmf_pkg::lmf_det_t        det_ff;
	lmf_pkg::lmf_det_t        nxt_det;
	logic [1:0]               sel_prev_ff;
	logic [1:0]               kind_ff;
	logic [1:0]               nxt_kind;
	logic [lmf_pkg::LEDS-1:0] nxt_open;
	logic [lmf_pkg::LEDS-1:0] nxt_short;
	logic                     trigger;
	logic                     sample;

	// Only a change away from off arms a pass [R3] [R8]
	assign trigger = (sel_prev_ff == lmf_pkg::DET_OFF) &&
		((detect_select == lmf_pkg::DET_OPEN) ||
		 (detect_select == lmf_pkg::DET_SHORT));
	assign sample = (det_ff == lmf_pkg::DT_RUN) && driving &&
		(cnt_ff == lmf_pkg::SAMPLE_STEP);

	always_comb begin
		nxt_det = det_ff;
		nxt_kind = kind_ff;
		unique case (det_ff)
			lmf_pkg::DT_IDLE: begin
				if (trigger) begin
					nxt_det = lmf_pkg::DT_WAIT;
					nxt_kind = detect_select;
				end
			end
			// Start on a row 0 boundary so one pass covers each row
			lmf_pkg::DT_WAIT: begin
				if (scan_wrap) begin
					nxt_det = lmf_pkg::DT_RUN;
				end
			end
			lmf_pkg::DT_RUN: begin
				if (scan_wrap) begin
					nxt_det = lmf_pkg::DT_IDLE; // [R8]
				end
			end
			default: begin
				nxt_det = lmf_pkg::DT_IDLE;
			end
		endcase
	end

	always_comb begin
		int idx;
		idx = 0;
		nxt_open = open_result_ff; // [R18]
		nxt_short = short_result_ff; // [R18]
		if (sample) begin
			for (int c = 0; c < lmf_pkg::COLS; c++) begin
				idx = int'(row_ff) * lmf_pkg::COLS + c;
				if (idx < lmf_pkg::LEDS && led_enable[idx]) begin // [R5]
					if (kind_ff == lmf_pkg::DET_OPEN) begin
						nxt_open[idx] = fault_sense[c]; // [R15] [R16]
					end else begin
						nxt_short[idx] = fault_sense[c]; // [R15] [R17]
					end
				end
			end
		end
	end

	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			det_ff <= lmf_pkg::DT_IDLE;
			sel_prev_ff <= lmf_pkg::DET_OFF;
			kind_ff <= lmf_pkg::DET_OFF;
			detect_busy_ff <= 1'b0;
			open_result_ff <= '0;
			short_result_ff <= '0;
		end else begin
			det_ff <= nxt_det;
			sel_prev_ff <= detect_select;
			kind_ff <= nxt_kind;
			detect_busy_ff <= (nxt_det != lmf_pkg::DT_IDLE);
			open_result_ff <= nxt_open;
			short_result_ff <= nxt_short;
		end
	end
endmodule

// ==== lmf_fault_model.sv ====
module lmf_fault_model (
	// Lit row
	input  wire logic [10:0]  row_on,
	// Injected faults
	input  wire logic [197:0] fault_map,
	// Comparators
	output logic      [17:0]  fault_sense
);
	timeunit 1ns;
	timeprecision 1ns;
	always_comb begin
		// No lit row: comparators float high
		fault_sense = '1;
		for (int r = 0; r < 11; r++) begin
			if (row_on[r]) begin
				fault_sense = fault_map[r*18 +: 18];
			end
		end
	end
endmodule

// ==== lmf_props.sv ====
module lmf_props (
	// Clock and reset
	input wire logic         mclk,
	input wire logic         rst_n,
	// Controls
	input wire logic [1:0]   detect_select,
	input wire logic [7:0]   pull_select,
	input wire logic         soft_shutdown_n,
	input wire logic         shutdown_pin_n,
	// Outputs
	input wire logic [10:0]  row_switch_ff,
	input wire logic [17:0]  column_sink_ff,
	input wire logic [10:0]  row_pulldown_ff,
	input wire logic [10:0]  row_pullup_ff,
	input wire logic [17:0]  column_pullup_ff,
	input wire logic         detect_busy_ff,
	input wire logic         analog_on_ff,
	input wire logic [197:0] open_result_ff,
	input wire logic [197:0] short_result_ff
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rst_n);
	a_soft_blank: assert property (
		$past(rst_n) && !$past(soft_shutdown_n)
		|-> row_switch_ff == '0 && column_sink_ff == '0
	) else $error("matrix lit in soft shutdown");
	a_hw_off: assert property (
		$past(rst_n) |-> analog_on_ff == $past(shutdown_pin_n) &&
		($past(shutdown_pin_n) || row_switch_ff == '0 &&
		column_pullup_ff == '0 && row_pulldown_ff == '0)
	) else $error("hardware shutdown not obeyed");
	a_row_pullup: assert property (
		$past(rst_n) && $past(shutdown_pin_n) && $past(pull_select) == 8'h30
		|-> row_pullup_ff == ~row_switch_ff && row_pulldown_ff == '0
	) else $error("row pull-up wrong");
	a_col_pullup: assert property (
		$past(rst_n) && $past(shutdown_pin_n) && $past(pull_select) != 8'h00
		|-> column_pullup_ff == ~column_sink_ff
	) else $error("column pull-up wrong");
	a_pull_when_off: assert property (
		((row_pulldown_ff | row_pullup_ff) & row_switch_ff) == '0 &&
		(column_pullup_ff & column_sink_ff) == '0
	) else $error("pull on a conducting output");
	a_det_start: assert property (
		$past(rst_n) && shutdown_pin_n && !detect_busy_ff &&
		$past(detect_select) == 2'h0 && detect_select inside {2'h1, 2'h2}
		|=> detect_busy_ff
	) else $error("detection not started");
	// ==========================================
	// Busy time, counted only while the scan can advance
	localparam int DET_MAX = 6100;
	logic [12:0] busy_cyc_ff;
	always_ff @(posedge mclk) begin
		if (!rst_n || !detect_busy_ff) begin
			busy_cyc_ff <= '0;
		end else if (shutdown_pin_n && busy_cyc_ff != 13'h1fff) begin
			busy_cyc_ff <= busy_cyc_ff + 13'h0001;
		end
	end
	a_det_bound: assert property (
		busy_cyc_ff <= 13'(DET_MAX)
	) else $error("detection pass too long");
	a_result_hold: assert property (
		$past(rst_n) && !detect_busy_ff && !$past(detect_busy_ff)
		|-> $stable(open_result_ff) && $stable(short_result_ff)
	) else $error("results changed while idle");
endmodule
bind lmf_matrix_ctrl lmf_props u_props (.mclk, .rst_n, .detect_select,
	.pull_select, .soft_shutdown_n, .shutdown_pin_n, .row_switch_ff,
	.column_sink_ff, .row_pulldown_ff, .row_pullup_ff, .column_pullup_ff,
	.detect_busy_ff, .analog_on_ff, .open_result_ff, .short_result_ff);

// ==== testbench.sv ====
module testbench;
	timeunit 1ns;
	timeprecision 1ns;
	logic         mclk = 1'b0;
	logic         rst_n = 1'b0;
	logic         pwm_wr_en = 1'b0;
	logic [3:0]   pwm_wr_row = 4'h0;
	logic [4:0]   pwm_wr_col = 5'h00;
	logic [7:0]   pwm_wr_data = 8'h00;
	logic [197:0] led_enable = '1;
	logic [1:0]   detect_select = 2'h0;
	logic [7:0]   pull_select = 8'h30;
	logic         soft_shutdown_n = 1'b1;
	logic         shutdown_pin_n = 1'b1;
	logic [17:0]  fault_sense;
	logic [197:0] fault_map = '0;
	logic [10:0]  row_switch_ff;
	logic [17:0]  column_sink_ff;
	logic [10:0]  row_pulldown_ff;
	logic [10:0]  row_pullup_ff;
	logic [17:0]  column_pullup_ff;
	logic [28:0]  lit_acc = '0;
	logic         detect_busy_ff;
	logic         analog_on_ff;
	logic [197:0] open_result_ff;
	logic [197:0] short_result_ff;
	logic [197:0] pat_a = {66{3'h5}};
	logic [197:0] pat_b = {66{3'h3}};
	logic [197:0] off_m = {11{18'h00003}};
	int           failures = 0;
	int           n_tests = 0;
	int           cycles = 0;
	int           cnt [3];
	lmf_matrix_ctrl dut (.mclk, .rst_n, .pwm_wr_en, .pwm_wr_row, .pwm_wr_col,
		.pwm_wr_data, .led_enable, .detect_select, .pull_select,
		.soft_shutdown_n, .shutdown_pin_n, .fault_sense, .row_switch_ff,
		.column_sink_ff, .row_pulldown_ff, .row_pullup_ff,
		.column_pullup_ff, .detect_busy_ff, .analog_on_ff, .open_result_ff,
		.short_result_ff);
	lmf_fault_model u_fault (.row_on(row_switch_ff), .fault_map, .fault_sense);
	// ==========================================
	// Helpers
	always #20 mclk = ~mclk;
	always @(posedge mclk) begin
		cycles++;
		if (cycles == 40000) begin
			chk("cycle_limit", '0, '1);
			wrap_up;
		end
	end
	task automatic chk(string name, logic [197:0] seen, exp);
		n_tests++;
		if (seen !== exp) begin
			failures++;
			$display("ERROR %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task automatic wrap_up;
		$display("checks %0d failures %0d", n_tests, failures);
		if (failures == 0 && n_tests > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask
	task automatic tick;
		@(posedge mclk);
		#1;
	endtask
	task automatic wr(int r, int c, logic [7:0] d);
		pwm_wr_en = 1'b1;
		pwm_wr_row = 4'(r);
		pwm_wr_col = 5'(c);
		pwm_wr_data = d;
		tick;
	endtask
	// Count sink cycles of columns 0..2 over the next row 0 drive
	task automatic meas;
		cnt = '{0, 0, 0};
		while (row_switch_ff[0] === 1'b1) tick;
		while (row_switch_ff[0] !== 1'b1) tick;
		while (row_switch_ff[0] === 1'b1) begin
			for (int i = 0; i < 3; i++) cnt[i] += int'(column_sink_ff[i] === 1'b1);
			tick;
		end
	endtask
	task automatic det(logic [1:0] code, logic [197:0] eo, es);
		detect_select = code;
		tick;
		tick;
		chk("detect_busy", 198'(detect_busy_ff), 198'(1));
		while (detect_busy_ff === 1'b1) tick;
		detect_select = 2'h0;
		tick;
		chk("open_result", open_result_ff, eo);
		chk("short_result", short_result_ff, es);
		$display("detect pass %0d done", code);
	endtask
	// ==========================================
	// Tests
	initial begin
		repeat (5) @(posedge mclk);
		#1;
		rst_n = 1'b1;
		for (int r = 0; r < 11; r++)
			for (int c = 0; c < 18; c++)
				wr(r, c, c == 0 ? 8'h04 : c == 1 ? 8'h00 : c == 2 ? 8'hff : 8'h10);
		pwm_wr_en = 1'b0;
		meas;
		chk("steps_col0", 198'(cnt[0]), 198'(4));
		chk("steps_col1", 198'(cnt[1]), 198'(0));
		chk("steps_col2", 198'(cnt[2]), 198'(255));
		// Into row 1 drive: some sinks on, some off
		repeat (30) tick;
		chk("row_pullup", 198'(row_pullup_ff),
			198'(11'(~row_switch_ff)));
		chk("col_pullup", 198'(column_pullup_ff),
			198'(18'(~column_sink_ff)));
		chk("row_pd_off", 198'(row_pulldown_ff), 198'(0));
		$display("pwm steps test done");
		shutdown_pin_n = 1'b0;
		pull_select = 8'h05;
		wr(0, 0, 8'h07);
		pwm_wr_en = 1'b0;
		tick;
		chk("analog_on", 198'(analog_on_ff), 198'(0));
		chk("rows_off", 198'(row_switch_ff), 198'(0));
		chk("pulls_off", 198'({row_pulldown_ff, row_pullup_ff,
			column_pullup_ff}), 198'(0));
		shutdown_pin_n = 1'b1;
		meas;
		chk("steps_after_hw", 198'(cnt[0]), 198'(7));
		chk("kept_col2", 198'(cnt[2]), 198'(255));
		repeat (30) tick;
		chk("row_pulldown", 198'(row_pulldown_ff),
			198'(11'(~row_switch_ff)));
		chk("row_pu_off", 198'(row_pullup_ff), 198'(0));
		$display("hardware shutdown test done");
		soft_shutdown_n = 1'b0;
		lit_acc = '0;
		repeat (300) begin
			tick;
			lit_acc |= {row_switch_ff, column_sink_ff};
		end
		chk("sinks_soft", 198'(column_sink_ff), 198'(0));
		chk("lit_soft", 198'(lit_acc), 198'(0));
		soft_shutdown_n = 1'b1;
		$display("soft shutdown test done");
		pull_select = 8'h00;
		fault_map = pat_a;
		det(2'h1, pat_a, '0);
		fault_map = pat_b;
		det(2'h2, pat_a, pat_b);
		led_enable = ~off_m;
		det(2'h1, (pat_b & ~off_m) | (pat_a & off_m), pat_b);
		wrap_up;
	end
endmodule
